// file: rtl/fwp_defs.svh
// Purpose: offsets, field positions, reset values, opcodes and timing counts of the write-protect block
// Assumes: included by its bare name from every file that needs it
// Notes: definitions only
`ifndef FWP_DEFS_SVH
`define FWP_DEFS_SVH

// register byte offsets
`define FWP_OFS_STATUS 8'h00
`define FWP_OFS_CONFIG 8'h04
`define FWP_OFS_RESULT 8'h08

// status byte fields, status reset value and config select bit
`define FWP_SR_BUSY 0
`define FWP_SR_WEL 1
`define FWP_SR_BP_LO 2
`define FWP_SR_BP_HI 5
`define FWP_SR_QE 6
`define FWP_SR_STATUS_WRITE_DISABLE 7
`define FWP_SR_RESET 8'h00
`define FWP_CFG_TBS 0

// block geometry and idle pin levels
`define FWP_NUM_BLOCKS 10'd512
`define FWP_BP_ALL 4'hA
`define FWP_BLK_LSB 16
`define FWP_PINS_IDLE 5'h0B

// frame lengths in serial bits
`define FWP_BITS_OP 6'd8
`define FWP_BITS_SRDATA 6'd16
`define FWP_BITS_A24 6'd32
`define FWP_BITS_A32 6'd40

// guarded opcodes
`define FWP_OP_PP 8'h02
`define FWP_OP_PP_A32 8'h12
`define FWP_OP_PPQ_A 8'h32
`define FWP_OP_PPQ_B 8'h38
`define FWP_OP_PPQ_A32_A 8'h34
`define FWP_OP_PPQ_A32_B 8'h3E
`define FWP_OP_SER_A 8'hD7
`define FWP_OP_SER_B 8'h20
`define FWP_OP_SER_A32 8'h21
`define FWP_OP_HBE 8'h52
`define FWP_OP_HBE_A32 8'h5C
`define FWP_OP_BE 8'hD8
`define FWP_OP_BE_A32 8'hDC
`define FWP_OP_CE_A 8'hC7
`define FWP_OP_CE_B 8'h60
`define FWP_OP_SRW 8'h01
`define FWP_OP_FRW 8'h42
`define FWP_OP_RPNV 8'h65
`define FWP_OP_ERPNV 8'h85
`define FWP_OP_IRE 8'h64
`define FWP_OP_IRP 8'h62
`define FWP_OP_BOOTW 8'h15
`define FWP_OP_BANKW 8'h18
`define FWP_OP_PPW 8'hFD
`define FWP_OP_PPW_A32 8'hE3
`define FWP_OP_PPE 8'hE4
`define FWP_OP_ADVP 8'h2F
`define FWP_OP_PLW 8'hA6
`define FWP_OP_FRZ 8'h91
`define FWP_OP_PWDP 8'hE8

// operation time
`define FWP_CLK_PERIOD_NS 4
`define FWP_OP_TIME_NS 64
`define FWP_OP_CYCLES ((`FWP_OP_TIME_NS + `FWP_CLK_PERIOD_NS - 1) / `FWP_CLK_PERIOD_NS)

`endif

// file: rtl/fwp_pkg.sv
// Purpose: types shared by the write-protect block
// Assumes: nothing
// Notes: class order is needs_wel, addressed, a32, status_wr, chip_erase, known
package fwp_pkg;
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic io2;
    logic io3;
  } fwp_pins_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FRAME = 3'b010,
    ST_BUSY = 3'b100
  } fwp_state_e;

  typedef struct packed {
    logic needs_wel;
    logic addressed;
    logic a32;
    logic status_wr;
    logic chip_erase;
    logic known;
  } fwp_class_s;

  typedef struct packed {
    logic lock_ref;
    logic prot_ref;
    logic wel_ref;
    logic accepted;
    logic [7:0] opcode;
  } fwp_result_s;

  localparam fwp_class_s CL_NONE = 6'b000000;
  localparam fwp_class_s CL_A24 = 6'b110001;
  localparam fwp_class_s CL_A32 = 6'b111001;
  localparam fwp_class_s CL_SRW = 6'b100101;
  localparam fwp_class_s CL_CE = 6'b100011;
  localparam fwp_class_s CL_PLAIN = 6'b100001;
endpackage

// file: rtl/fwp_sync2.sv
// Purpose: two-stage synchroniser for the serial link pins
// Assumes: pins are asynchronous to CLOCK_I
// Notes: first stage feeds the second stage only
`timescale 1ns/1ns
`include "fwp_defs.svh"
module fwp_sync2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire fwp_pkg::fwp_pins_s pins_i,
  output fwp_pkg::fwp_pins_s pins_o
);
  import fwp_pkg::*;

  fwp_pins_s meta_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= fwp_pins_s'(`FWP_PINS_IDLE);
      pins_o <= fwp_pins_s'(`FWP_PINS_IDLE);
    end
    else
    begin
      meta_r <= pins_i;
      pins_o <= meta_r;
    end
  end
endmodule

// file: rtl/fwp_range.sv
// Purpose: decides whether a 64 KB block lies in the protected area
// Assumes: block index 0..511, protect field and top/bottom select from status and config
// Notes: purely combinational
`timescale 1ns/1ns
`include "fwp_defs.svh"
module fwp_range (
  input wire logic [3:0] bp_i,
  input wire logic tbs_i,
  input wire logic [8:0] blk_i,
  output logic hit_o
);
  import fwp_pkg::*;

  logic [9:0] span;
  logic [9:0] blk_w;

  always_comb
  begin
    span = 10'(10'd1 << (bp_i - 4'd1));
    blk_w = {1'b0, blk_i};
    if (bp_i == 4'h0)
      hit_o = 1'b0;
    else if (bp_i >= `FWP_BP_ALL)
      hit_o = 1'b1; // see [R12]
    else if (tbs_i)
      hit_o = blk_w < span; // see [R11] see [R13]
    else
      hit_o = blk_w >= (`FWP_NUM_BLOCKS - span); // see [R11] see [R13]
  end
endmodule

// file: rtl/fwp_top.sv
// Purpose: write-protect gate of a serial flash: latch, protected range, status lock, pin roles
// Assumes: mode-0 single-line frames, SCK well below CLOCK_I/4, AHB-Lite single word transfers
// Notes: granted operations leave as a start pulse with opcode and address
// Operation
// [R01] page programs need the write latch set
// [R02] sector and half block erase need latch
// [R03] 32-bit half erase, block erases need latch
// [R04] chip erase needs latch, ignored if protected
// [R05] status, function, read-param writes need latch
// [R06] ext read-param, info row ops need latch
// [R07] boot, bank, persist-protect writes need latch
// [R08] persist 32-bit write, erase, advanced need latch
// [R09] lock bit, freeze, password need latch
// [R10] block program or erase inside range
// [R11] codes 1-9 protect 2^(code-1) blocks
// [R12] codes 10-15 protect all blocks
// [R13] select 0 from top, 1 from bottom
// [R14] disable bit 0 allows status writes
// [R15] disable 1, pin low locks status
// [R16] disable 1, pin high allows writes
// [R17] quad off: pins are protect, hold
// [R18] quad on: pins are data lines
// [R19] latch set, cleared, cleared after operation
// [R20] status byte layout, all zero reset
// [R21] block index from address upper bits
`timescale 1ns/1ns
`include "fwp_defs.svh"
module fwp_top #(
  parameter logic [7:0] LATCH_SET_OP = 8'h06,
  parameter logic [7:0] LATCH_CLR_OP = 8'h04
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // serial link
  input wire logic SCK_I,
  input wire logic CS_N_I,
  input wire logic SI_I,
  input wire logic IO2_I,
  output logic IO2_O,
  output logic IO2_OE_N_O,
  input wire logic IO3_I,
  output logic IO3_O,
  output logic IO3_OE_N_O,
  // granted operation, busy and hold state
  output logic OP_START_O,
  output logic [7:0] OP_CODE_O,
  output logic [31:0] OP_ADDR_O,
  output logic BUSY_O,
  output logic HOLD_ACTIVE_O
);
  import fwp_pkg::*;

  localparam logic [4:0] BUSY_LAST = 5'(`FWP_OP_CYCLES - 1);

  fwp_pins_s pins_in;
  fwp_pins_s pins_s;
  fwp_pins_s pins_prev_r;
  fwp_state_e state_r;
  logic [7:0] status_r;
  logic tbs_r;
  fwp_result_s result_r;
  logic [7:0] op_r;
  logic [31:0] arg_r;
  logic [5:0] bit_cnt_r;
  logic [4:0] busy_cnt_r;
  logic ahb_wr_r;
  logic [7:0] ahb_addr_r;
  logic sck_rise;
  logic cs_rise;
  logic cs_fall;
  logic wp_low;
  logic hold_low;
  logic [3:0] bp;
  logic [8:0] blk;
  logic prot_hit;
  fwp_class_s cls;
  logic [5:0] need_bits;
  logic decide;
  logic refuse_wel;
  logic refuse_prot;
  logic refuse_lock;
  logic accept;
  logic busy_done;

  function automatic fwp_class_s classify(input logic [7:0] op);
    fwp_class_s c;
    c = CL_NONE;
    case (op)
      `FWP_OP_PP, `FWP_OP_PPQ_A, `FWP_OP_PPQ_B: c = CL_A24; // see [R01]
      `FWP_OP_PP_A32, `FWP_OP_PPQ_A32_A, `FWP_OP_PPQ_A32_B: c = CL_A32; // see [R01]
      `FWP_OP_SER_A, `FWP_OP_SER_B, `FWP_OP_HBE: c = CL_A24; // see [R02]
      `FWP_OP_SER_A32: c = CL_A32; // see [R02]
      `FWP_OP_HBE_A32, `FWP_OP_BE_A32: c = CL_A32; // see [R03]
      `FWP_OP_BE: c = CL_A24; // see [R03]
      `FWP_OP_CE_A, `FWP_OP_CE_B: c = CL_CE; // see [R04]
      `FWP_OP_SRW: c = CL_SRW; // see [R05]
      `FWP_OP_FRW, `FWP_OP_RPNV: c = CL_PLAIN; // see [R05]
      `FWP_OP_ERPNV, `FWP_OP_IRE, `FWP_OP_IRP: c = CL_PLAIN; // see [R06]
      `FWP_OP_BOOTW, `FWP_OP_BANKW, `FWP_OP_PPW: c = CL_PLAIN; // see [R07]
      `FWP_OP_PPW_A32, `FWP_OP_PPE, `FWP_OP_ADVP: c = CL_PLAIN; // see [R08]
      `FWP_OP_PLW, `FWP_OP_FRZ, `FWP_OP_PWDP: c = CL_PLAIN; // see [R09]
      default: c = CL_NONE;
    endcase
    return c;
  endfunction

  // link pins, both quad pins sampled whatever their role
  always_comb
  begin
    pins_in.sck = SCK_I;
    pins_in.cs_n = CS_N_I;
    pins_in.si = SI_I;
    pins_in.io2 = IO2_I;
    pins_in.io3 = IO3_I;
  end

  fwp_sync2 u_sync (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .pins_i(pins_in),
    .pins_o(pins_s)
  );

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      pins_prev_r <= fwp_pins_s'(`FWP_PINS_IDLE);
    else
      pins_prev_r <= pins_s;
  end

  // quad mode turns both control pins into data, so neither protect nor hold acts
  assign wp_low = !status_r[`FWP_SR_QE] && !pins_s.io2; // see [R17] see [R18]
  assign hold_low = !status_r[`FWP_SR_QE] && !pins_s.io3; // see [R17] see [R18]
  assign sck_rise = pins_s.sck && !pins_prev_r.sck && !pins_s.cs_n && !hold_low;
  assign cs_rise = pins_s.cs_n && !pins_prev_r.cs_n;
  assign cs_fall = !pins_s.cs_n && pins_prev_r.cs_n;

  // frame capture: opcode first, then address or data byte msb first
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      op_r <= 8'h00;
      arg_r <= 32'h0000_0000;
      bit_cnt_r <= 6'd0;
    end
    else if (state_r == ST_IDLE && cs_fall)
    begin
      op_r <= 8'h00;
      arg_r <= 32'h0000_0000;
      bit_cnt_r <= 6'd0;
    end
    else if (state_r == ST_FRAME && sck_rise && bit_cnt_r < `FWP_BITS_A32)
    begin
      if (bit_cnt_r < `FWP_BITS_OP)
        op_r <= {op_r[6:0], pins_s.si};
      else
        arg_r <= {arg_r[30:0], pins_s.si};
      bit_cnt_r <= bit_cnt_r + 6'd1;
    end
  end

  // decision at frame end
  assign bp = status_r[`FWP_SR_BP_HI:`FWP_SR_BP_LO];
  assign cls = classify(op_r);
  // short addresses carry no bank bit, so they reach the lower 256 blocks only
  assign blk = cls.a32 ? arg_r[`FWP_BLK_LSB+8:`FWP_BLK_LSB] : {1'b0, arg_r[`FWP_BLK_LSB+7:`FWP_BLK_LSB]}; // see [R21]

  fwp_range u_range (
    .bp_i(bp),
    .tbs_i(tbs_r),
    .blk_i(blk),
    .hit_o(prot_hit)
  );

  always_comb
  begin
    need_bits = `FWP_BITS_OP;
    if (cls.addressed)
      need_bits = cls.a32 ? `FWP_BITS_A32 : `FWP_BITS_A24;
    else if (cls.status_wr)
      need_bits = `FWP_BITS_SRDATA;
  end

  assign decide = state_r == ST_FRAME && cs_rise && cls.known;
  assign refuse_wel = cls.needs_wel && !status_r[`FWP_SR_WEL]; // see [R01] see [R05] see [R09]
  assign refuse_prot = (cls.addressed && prot_hit) || (cls.chip_erase && bp != 4'h0); // see [R10] see [R04]
  // disable bit clear or pin high leaves status writes open
  assign refuse_lock = cls.status_wr && status_r[`FWP_SR_STATUS_WRITE_DISABLE] && wp_low; // see [R14] see [R15] see [R16]
  assign accept = decide && bit_cnt_r >= need_bits && !refuse_wel && !refuse_prot && !refuse_lock;
  assign busy_done = state_r == ST_BUSY && busy_cnt_r == BUSY_LAST;

  // sequencer; frames arriving while busy are dropped whole
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE: if (cs_fall) state_r <= ST_FRAME;
        ST_FRAME: if (cs_rise) state_r <= accept ? ST_BUSY : ST_IDLE;
        ST_BUSY: if (busy_done) state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I || state_r != ST_BUSY)
      busy_cnt_r <= 5'd0;
    else
      busy_cnt_r <= busy_cnt_r + 5'd1;
  end

  // status byte
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      status_r <= `FWP_SR_RESET; // see [R20]
    else
    begin
      if (state_r == ST_FRAME && cs_rise && op_r == LATCH_SET_OP)
        status_r[`FWP_SR_WEL] <= 1'b1; // see [R19]
      else if (state_r == ST_FRAME && cs_rise && op_r == LATCH_CLR_OP)
        status_r[`FWP_SR_WEL] <= 1'b0; // see [R19]
      else if (busy_done)
        status_r[`FWP_SR_WEL] <= 1'b0; // see [R19]
      if (accept)
        status_r[`FWP_SR_BUSY] <= 1'b1;
      else if (busy_done)
        status_r[`FWP_SR_BUSY] <= 1'b0;
      // latch and busy bits are never written from the data byte
      if (accept && cls.status_wr)
        status_r[`FWP_SR_STATUS_WRITE_DISABLE:`FWP_SR_BP_LO] <= arg_r[`FWP_SR_STATUS_WRITE_DISABLE:`FWP_SR_BP_LO]; // see [R15]
    end
  end

  // outcome of the last guarded frame
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      result_r <= '0;
    else if (decide)
    begin
      result_r.opcode <= op_r;
      result_r.accepted <= accept;
      result_r.wel_ref <= refuse_wel;
      result_r.prot_ref <= refuse_prot;
      result_r.lock_ref <= refuse_lock;
    end
  end

  // granted operation towards the array
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      OP_START_O <= 1'b0;
      OP_CODE_O <= 8'h00;
      OP_ADDR_O <= 32'h0000_0000;
    end
    else
    begin
      OP_START_O <= accept;
      if (accept)
      begin
        OP_CODE_O <= op_r;
        OP_ADDR_O <= cls.a32 ? arg_r : {8'h00, arg_r[23:0]};
      end
    end
  end

  // this block only receives on the quad lines, so it never drives them
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      BUSY_O <= 1'b0;
      HOLD_ACTIVE_O <= 1'b0;
      IO2_O <= 1'b0;
      IO3_O <= 1'b0;
      IO2_OE_N_O <= 1'b1;
      IO3_OE_N_O <= 1'b1;
    end
    else
    begin
      BUSY_O <= accept || (state_r == ST_BUSY && !busy_done);
      HOLD_ACTIVE_O <= hold_low && !pins_s.cs_n; // see [R17]
      IO2_O <= 1'b0;
      IO3_O <= 1'b0;
      IO2_OE_N_O <= 1'b1; // see [R18]
      IO3_OE_N_O <= 1'b1; // see [R18]
    end
  end

  // ahb-lite slave, zero wait states
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      ahb_wr_r <= 1'b0;
      ahb_addr_r <= 8'h00;
      HRDATA_O <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
    else
    begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      ahb_wr_r <= HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
      ahb_addr_r <= HADDR_I[7:0];
      if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I)
      begin
        if (HADDR_I[31:8] != 24'h00_0000)
          HRDATA_O <= 32'h0000_0000;
        else if (HADDR_I[7:0] == `FWP_OFS_STATUS)
          HRDATA_O <= {24'h00_0000, status_r};
        else if (HADDR_I[7:0] == `FWP_OFS_CONFIG)
          HRDATA_O <= {31'h0000_0000, tbs_r};
        else if (HADDR_I[7:0] == `FWP_OFS_RESULT)
          HRDATA_O <= {20'h0_0000, result_r};
        else
          HRDATA_O <= 32'h0000_0000;
      end
    end
  end

  // top/bottom select is one-time: a written 1 stays
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      tbs_r <= 1'b0;
    else if (ahb_wr_r && ahb_addr_r == `FWP_OFS_CONFIG && HWDATA_I[`FWP_CFG_TBS])
      tbs_r <= 1'b1; // see [R13]
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  a_start_needs_wel: assert property (OP_START_O |-> $past(status_r[`FWP_SR_WEL])) // see [R01]
    else $error("operation started without write latch");
  a_chip_erase_bp: assert property (OP_START_O && (OP_CODE_O == `FWP_OP_CE_A || OP_CODE_O == `FWP_OP_CE_B)
    |-> $past(bp) == 4'h0) // see [R04]
    else $error("chip erase started with protection set");
  a_protected_block: assert property (accept |-> !(cls.addressed && prot_hit)) // see [R10]
    else $error("operation granted inside protected range");
  a_top_one_block: assert property (bp == 4'h1 && !tbs_r |-> prot_hit == (blk == 9'd511)) // see [R11]
    else $error("code 1 top range wrong");
  a_bottom_half: assert property (bp == 4'h9 && tbs_r |-> prot_hit == (blk < 9'd256)) // see [R13]
    else $error("code 9 bottom range wrong");
  a_all_blocks: assert property (bp >= 4'hA |-> prot_hit) // see [R12]
    else $error("codes 10-15 must protect all");
  a_status_locked: assert property (status_r[`FWP_SR_STATUS_WRITE_DISABLE] && wp_low && state_r != ST_BUSY
    |=> $stable(status_r[`FWP_SR_STATUS_WRITE_DISABLE:`FWP_SR_BP_LO])) // see [R15]
    else $error("locked status bits changed");
  a_status_open: assert property (decide && cls.status_wr && !status_r[`FWP_SR_STATUS_WRITE_DISABLE]
    && status_r[`FWP_SR_WEL] && bit_cnt_r >= `FWP_BITS_SRDATA |-> accept) // see [R14]
    else $error("open status write refused");
  a_busy_hold: assert property ($rose(status_r[`FWP_SR_BUSY]) |-> status_r[`FWP_SR_BUSY] [*8]) // see [R19]
    else $error("busy dropped early");
  a_done_clears: assert property ($fell(status_r[`FWP_SR_BUSY]) |-> !status_r[`FWP_SR_WEL]) // see [R19]
    else $error("latch not cleared after operation");
  a_quad_no_hold: assert property (status_r[`FWP_SR_QE] |=> !HOLD_ACTIVE_O) // see [R18]
    else $error("hold active in quad mode");
endmodule

// file: tb/fwp_host.sv
// Purpose: behavioural serial host that frames opcodes for the write-protect block
// Assumes: mode 0, 80 ns serial clock, msb first, bits offset 1 ns from the system clock
// Notes: serial clock stands low between frames; data line flips once released
`timescale 1ns/1ns
module fwp_host (
  // link
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // caller sends a latch-set frame before each guarded one except the unlatched refusal frame in the opcode loop
  task automatic frame(input logic [39:0] bits, input int n);
    int i;
    #1 cs_n_o = 1'b0;
    for (i = 39; i >= 40 - n; i--)
    begin
      si_o = bits[i];
      #40 sck_o = 1'b1;
      #40 sck_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    // released line must not keep its last level
    si_o = ~si_o;
    #120;
  endtask
  task automatic select(input logic v);
    #1 cs_n_o = v;
  endtask
endmodule

// file: tb/test_flash_write_protect_logic.sv
// Purpose: self-checking bench of the write-protect gate
// Assumes: bus answers without wait states but the master still waits for hready
// Notes: link frames come from the host model; expectations rebuilt from opcode lists
`timescale 1ns/1ns
`include "fwp_defs.svh"
module test_flash_write_protect_logic;
  import fwp_pkg::*;
  localparam logic [7:0] LSET = 8'h06;
  localparam logic [7:0] LCLR = 8'h04;
  localparam int LIMIT = 100000;
  localparam logic [7:0] OPS [30] = '{`FWP_OP_PP, `FWP_OP_PP_A32, `FWP_OP_PPQ_A, `FWP_OP_PPQ_B, `FWP_OP_PPQ_A32_A,
    `FWP_OP_PPQ_A32_B, `FWP_OP_SER_A, `FWP_OP_SER_B, `FWP_OP_SER_A32, `FWP_OP_HBE, `FWP_OP_HBE_A32, `FWP_OP_BE,
    `FWP_OP_BE_A32, `FWP_OP_CE_A, `FWP_OP_CE_B, `FWP_OP_SRW, `FWP_OP_FRW, `FWP_OP_RPNV, `FWP_OP_ERPNV, `FWP_OP_IRE,
    `FWP_OP_IRP, `FWP_OP_BOOTW, `FWP_OP_BANKW, `FWP_OP_PPW, `FWP_OP_PPW_A32, `FWP_OP_PPE, `FWP_OP_ADVP,
    `FWP_OP_PLW, `FWP_OP_FRZ, `FWP_OP_PWDP};
  localparam logic [3:0] BPS [4] = '{4'h1, 4'h9, 4'hA, 4'h0};
  logic clk, rst, hsel, hwrite, hready, io2, io3, sck, cs_n, si;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic hresp, op_start, busy, hold;
  logic io2_o, io3_o, io2_oe_n, io3_oe_n;
  logic [31:0] op_addr;
  logic [7:0] op_code;
  int n_mismatch, check_count, n_start, n_busy, cyc, i, t, k;
  logic [9:0] e;

  fwp_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si));
  fwp_top #(.LATCH_SET_OP(LSET), .LATCH_CLR_OP(LCLR)) dut (.CLOCK_I(clk), .RST_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .SCK_I(sck), .CS_N_I(cs_n),
    .SI_I(si), .IO2_I(io2), .IO2_O(io2_o), .IO2_OE_N_O(io2_oe_n), .IO3_I(io3), .IO3_O(io3_o),
    .IO3_OE_N_O(io3_oe_n), .OP_START_O(op_start), .OP_CODE_O(op_code), .OP_ADDR_O(op_addr), .BUSY_O(busy),
    .HOLD_ACTIVE_O(hold));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (op_start === 1'b1)
      n_start++;
    if (busy === 1'b1)
      n_busy++;
    cyc++;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    d = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(a, 1'b0, 32'h0);
    chk(d, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // one frame, then the pulse count and the granted opcode
  task automatic op(input logic [7:0] c, input logic [31:0] w, input int n, input logic grant);
    int s0;
    int b0;
    int j;
    s0 = n_start;
    b0 = n_busy;
    j = 0;
    host.frame({c, w}, n);
    // bounded wait so a stuck busy still reaches the verdict
    while (busy !== 1'b0 && j < 64)
    begin
      @(posedge clk);
      j++;
    end
    @(posedge clk);
    chk(32'(n_start - s0), {31'h0, grant});
    chk(32'(n_busy - b0), grant ? 32'(`FWP_OP_CYCLES) : 32'h0);
    if (grant)
      chk({24'h0, op_code}, {24'h0, c});
  endtask
  task automatic status_write_cmd(input logic [7:0] v, input logic grant);
    op(LSET, 32'h0, 8, 1'b0);
    op(`FWP_OP_SRW, {v, 24'h0}, 16, grant);
  endtask
  function automatic logic hit(input logic [3:0] bp, input logic tb, input logic [9:0] b);
    int n;
    n = (bp == 4'h0) ? 0 : (bp >= 4'hA) ? 512 : (1 << (bp - 1));
    return tb ? (b < n) : (b >= 512 - n);
  endfunction

  initial
  begin
    rst = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    io2 = 1'b1;
    io3 = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`FWP_OFS_STATUS, 32'h0);
    rd_chk(`FWP_OFS_CONFIG, 32'h0);
    rd_chk(`FWP_OFS_RESULT, 32'h0);
    ahb(8'h40, 1'b1, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0);
    $display("test reset done");
    op(LSET, 32'h0, 8, 1'b0);
    rd_chk(`FWP_OFS_STATUS, 32'h02);
    op(LCLR, 32'h0, 8, 1'b0);
    rd_chk(`FWP_OFS_STATUS, 32'h00);
    $display("test latch done");
    for (i = 0; i < 30; i++)
    begin
      op(OPS[i], 32'h0, 40, 1'b0);
      rd_chk(`FWP_OFS_RESULT, {20'h0, 4'b0010, OPS[i]});
      op(LSET, 32'h0, 8, 1'b0);
      op(OPS[i], 32'h0, 40, 1'b1);
      rd_chk(`FWP_OFS_RESULT, {20'h0, 4'b0001, OPS[i]});
      rd_chk(`FWP_OFS_STATUS, 32'h0);
    end
    $display("test guarded opcodes done");
    for (t = 0; t < 2; t++)
    begin
      if (t == 1)
      begin
        ahb(`FWP_OFS_CONFIG, 1'b1, 32'h1);
        rd_chk(`FWP_OFS_CONFIG, 32'h1);
      end
      for (i = 0; i < 4; i++)
      begin
        status_write_cmd({2'b00, BPS[i], 2'b00}, 1'b1);
        rd_chk(`FWP_OFS_STATUS, {26'h0, BPS[i], 2'b00});
        e = t ? ((BPS[i] == 0) ? 10'd0 : (BPS[i] >= 4'hA) ? 10'd512 : 10'd1 << (BPS[i] - 1)) : 10'd0;
        if (t == 0)
          e = 10'd512 - ((BPS[i] == 0) ? 10'd0 : (BPS[i] >= 4'hA) ? 10'd512 : 10'd1 << (BPS[i] - 1));
        for (k = 0; k < 2; k++)
        begin
          e = (e - 10'(k)) & 10'h1FF;
          op(LSET, 32'h0, 8, 1'b0);
          op(`FWP_OP_BE_A32, {7'h0, e[8:0], 16'h0}, 40, !hit(BPS[i], t[0], e));
          if (!hit(BPS[i], t[0], e))
            chk(op_addr, {7'h0, e[8:0], 16'h0});
        end
      end
      $display("test protected range done");
    end
    status_write_cmd(8'h04, 1'b1);
    op(LSET, 32'h0, 8, 1'b0);
    op(`FWP_OP_CE_A, 32'h0, 40, 1'b0);
    rd_chk(`FWP_OFS_STATUS, 32'h06);
    rd_chk(`FWP_OFS_RESULT, 32'h0000_04C7);
    io2 <= 1'b0;
    status_write_cmd(8'h80, 1'b1);
    status_write_cmd(8'h00, 1'b0);
    rd_chk(`FWP_OFS_STATUS, 32'h82);
    rd_chk(`FWP_OFS_RESULT, 32'h0000_0801);
    op(LCLR, 32'h0, 8, 1'b0);
    io2 <= 1'b1;
    status_write_cmd(8'hC0, 1'b1);
    io2 <= 1'b0;
    status_write_cmd(8'h40, 1'b1);
    rd_chk(`FWP_OFS_STATUS, 32'h40);
    io3 <= 1'b0;
    host.select(1'b0);
    repeat (8) @(posedge clk);
    chk({31'h0, hold}, 32'h0);
    host.select(1'b1);
    repeat (30) @(posedge clk);
    io3 <= 1'b1;
    io2 <= 1'b1;
    status_write_cmd(8'h00, 1'b1);
    io3 <= 1'b0;
    host.select(1'b0);
    repeat (8) @(posedge clk);
    chk({31'h0, hold}, 32'h1);
    host.select(1'b1);
    repeat (30) @(posedge clk);
    io3 <= 1'b1;
    chk({28'h0, io2_o, io3_o, io2_oe_n, io3_oe_n}, 32'h3);
    $display("test status lock and pin roles done");
    wrap_up();
  end
endmodule
